/* File: design/bioprt_line.sv */
// one port line: two-stage pin synchroniser and output driver
`timescale 1ns/100ps
`default_nettype none
module bioprt_line (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic pad_in,
  input wire logic dir_in,
  input wire logic out_val,
  output logic pad_sync,
  output logic pad_out,
  output logic pad_oe
);
  logic meta_r;
  logic sync_r;
  logic out_r;
  logic oe_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      meta_r <= pad_in;
      sync_r <= meta_r;
      out_r <= out_val;
      oe_r <= ~dir_in;
    end
  end
  assign pad_sync = sync_r;
  assign pad_out = out_r;
  assign pad_oe = oe_r;
endmodule
`default_nettype wire

/* File: design/bioprt_top.sv */
// three bidirectional ports with buzzer pair and shared pin functions
`timescale 1ns/100ps
`default_nettype none
`include "bioprt_consts.svh"
module bioprt_top #(
  parameter logic [7:0] PA_PULLUP = 8'h00,
  parameter logic [2:0] PB_PULLUP = 3'h0,
  parameter logic [1:0] PC_PULLUP = 2'h0,
  parameter logic [7:0] PA_WAKE_EN = 8'h00,
  parameter bit BUZZ_EN = 1'b0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire bioprt_pkg::bioprt_addr_t bus_addr,
  input wire bioprt_pkg::bioprt_byte_t bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_rmw,
  input wire bioprt_pkg::bioprt_op_e bus_op,
  input wire logic [2:0] bus_bit,
  input wire logic bus_to_acc,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic timer_overflow,
  input wire logic [12:0] pad_in,
  output logic [12:0] pad_out,
  output logic [12:0] pad_oe,
  output logic [12:0] pad_pullup,
  output logic wake_req,
  output logic ext_irq_line,
  output logic timer_input_line
);
  import bioprt_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] port_a_latch_r;
  logic [7:0] port_a_direction_r;
  logic [2:0] port_b_latch_r;
  logic [2:0] port_b_direction_r;
  logic [1:0] port_c_latch_r;
  logic [1:0] port_c_direction_r;
  logic tone_divider_signal_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic wake_r;
  logic irq_r;
  logic tmr_r;
  logic [12:0] pull_r;

  // ----------------------------------------
  // pin lines
  // ----------------------------------------
  logic [12:0] dir_all;
  logic [12:0] out_all;
  logic [12:0] pad_sync;
  logic [12:0] sync_prev_r;

  assign dir_all = {port_c_direction_r, port_b_direction_r, port_a_direction_r};

  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++) begin : g_line
      bioprt_line u_line (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pad_in(pad_in[gi]),
        .dir_in(dir_all[gi]),
        .out_val(out_all[gi]),
        .pad_sync(pad_sync[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe(pad_oe[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // buzzer output path
  // ----------------------------------------
  wire buzz_gate = port_b_latch_r[`BIOPRT_BUZZ_TRUE_BIT];
  wire buzzer_out = buzz_gate & tone_divider_signal_r;
  wire buzz_true_line = BUZZ_EN ? buzzer_out : port_b_latch_r[`BIOPRT_BUZZ_TRUE_BIT];
  wire buzz_inverse_line = BUZZ_EN ? (buzz_gate & ~tone_divider_signal_r)
    : port_b_latch_r[`BIOPRT_BUZZ_INV_BIT];
  assign out_all = {port_c_latch_r, port_b_latch_r[2], buzz_inverse_line, buzz_true_line,
    port_a_latch_r};

  // ----------------------------------------
  // read path
  // ----------------------------------------
  wire [7:0] pa_pad = pad_sync[7:0];
  wire [2:0] pb_pad = pad_sync[10:8];
  wire [1:0] pc_pad = pad_sync[12:11];
  // pad level when input, latch when output
  wire [7:0] pa_view = (port_a_direction_r & pa_pad) | (~port_a_direction_r & port_a_latch_r);
  wire [2:0] pb_view = (port_b_direction_r & pb_pad) | (~port_b_direction_r & port_b_latch_r);
  wire [1:0] pc_view = (port_c_direction_r & pc_pad) | (~port_c_direction_r & port_c_latch_r);

  wire sel_pa = (bus_addr == `BIOPRT_ADDR_PA_LATCH);
  wire sel_pac = (bus_addr == `BIOPRT_ADDR_PA_DIR);
  wire sel_pb = (bus_addr == `BIOPRT_ADDR_PB_LATCH);
  wire sel_pbc = (bus_addr == `BIOPRT_ADDR_PB_DIR);
  wire sel_pc = (bus_addr == `BIOPRT_ADDR_PC_LATCH);
  wire sel_pcc = (bus_addr == `BIOPRT_ADDR_PC_DIR);

  // absent upper bits read as zero
  wire [7:0] read_word = sel_pa ? pa_view :
    sel_pac ? port_a_direction_r :
    sel_pb ? {5'h00, pb_view} :
    sel_pbc ? {5'h00, port_b_direction_r} :
    sel_pc ? {6'h00, pc_view} :
    sel_pcc ? {6'h00, port_c_direction_r} : 8'h00;

  // ----------------------------------------
  // read-modify-write
  // ----------------------------------------
  wire [7:0] bit_mask = 8'h01 << bus_bit;
  logic [7:0] rmw_word;
  always_comb begin
    case (bus_op)
      BIOPRT_OP_SET: rmw_word = read_word | bit_mask;
      BIOPRT_OP_CLR: rmw_word = read_word & ~bit_mask;
      BIOPRT_OP_CPL: rmw_word = ~read_word;
      default: rmw_word = bus_wdata;
    endcase
  end
  // whole port result goes back to latch unless aimed at accumulator
  wire rmw_store = bus_rmw & ~bus_to_acc;
  wire do_write = bus_wr | rmw_store;
  wire [7:0] wr_word = bus_rmw ? rmw_word : bus_wdata;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_latch_r <= `BIOPRT_LATCH_RESET;
      port_b_latch_r <= 3'h7;
      port_c_latch_r <= 2'h3;
    end else if (do_write) begin
      if (sel_pa) port_a_latch_r <= wr_word;
      if (sel_pb) port_b_latch_r <= wr_word[2:0];
      if (sel_pc) port_c_latch_r <= wr_word[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_direction_r <= `BIOPRT_DIR_RESET;
      port_b_direction_r <= 3'h7;
      port_c_direction_r <= 2'h3;
    end else if (do_write) begin
      if (sel_pac) port_a_direction_r <= wr_word;
      if (sel_pbc) port_b_direction_r <= wr_word[2:0];
      if (sel_pcc) port_c_direction_r <= wr_word[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= bus_rd | (bus_rmw & bus_to_acc);
      if (bus_rd) rdata_r <= read_word;
      else if (bus_rmw & bus_to_acc) rdata_r <= rmw_word;
    end
  end

  // ----------------------------------------
  // tone divider: toggles on each timer overflow
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tone_divider_signal_r <= 1'b0;
    end else if (timer_overflow) begin
      tone_divider_signal_r <= ~tone_divider_signal_r;
    end
  end

  // ----------------------------------------
  // wake-up, shared inputs, pull-ups
  // ----------------------------------------
  wire [7:0] pa_edge = (pa_pad ^ sync_prev_r[7:0]) & port_a_direction_r & PA_WAKE_EN;
  wire [12:0] pull_nxt = {PC_PULLUP, PB_PULLUP, PA_PULLUP} & dir_all;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync_prev_r <= 13'h0000;
      wake_r <= 1'b0;
      irq_r <= 1'b1;
      tmr_r <= 1'b0;
      pull_r <= 13'h0000;
    end else begin
      sync_prev_r <= pad_sync;
      wake_r <= |pa_edge;
      irq_r <= pc_pad[`BIOPRT_IRQ_BIT];
      tmr_r <= pc_pad[`BIOPRT_TMR_BIT];
      pull_r <= pull_nxt;
    end
  end

  assign bus_rdata = rdata_r;
  assign bus_rvalid = rvalid_r;
  assign wake_req = wake_r;
  assign ext_irq_line = irq_r;
  assign timer_input_line = tmr_r;
  assign pad_pullup = pull_r;
endmodule
`default_nettype wire

/* File: pkg/bioprt_consts.svh */
// register map, reset values and widths of the i/o port block
`ifndef BIOPRT_CONSTS_SVH
`define BIOPRT_CONSTS_SVH
`define BIOPRT_ADDR_PA_LATCH 8'h12
`define BIOPRT_ADDR_PA_DIR 8'h13
`define BIOPRT_ADDR_PB_LATCH 8'h14
`define BIOPRT_ADDR_PB_DIR 8'h15
`define BIOPRT_ADDR_PC_LATCH 8'h16
`define BIOPRT_ADDR_PC_DIR 8'h17
`define BIOPRT_PA_WIDTH 8
`define BIOPRT_PB_WIDTH 3
`define BIOPRT_PC_WIDTH 2
`define BIOPRT_LATCH_RESET 8'hff
`define BIOPRT_DIR_RESET 8'hff
`define BIOPRT_TONE_FULL 9'h100
`define BIOPRT_BUZZ_TRUE_BIT 0
`define BIOPRT_BUZZ_INV_BIT 1
`define BIOPRT_IRQ_BIT 0
`define BIOPRT_TMR_BIT 1
`endif

/* File: pkg/bioprt_pkg.sv */
// types shared by the i/o port block
package bioprt_pkg;
  typedef logic [7:0] bioprt_byte_t;
  typedef logic [7:0] bioprt_addr_t;
  typedef enum logic [1:0] {
    BIOPRT_OP_WRITE = 2'b00,
    BIOPRT_OP_SET = 2'b01,
    BIOPRT_OP_CLR = 2'b10,
    BIOPRT_OP_CPL = 2'b11
  } bioprt_op_e;
endpackage

/* File: verif/bioprt_pads.sv */
// pin-side model: external drivers meet the port outputs
`timescale 1ns/100ps
`default_nettype none
module bioprt_pads (
  input wire logic [12:0] pad_out,
  input wire logic [12:0] pad_oe,
  input wire logic [12:0] ext_val,
  output logic [12:0] pad_in
);
  // an outside driver holds every released line, so the device sees it
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule
`default_nettype wire

/* File: verif/bioprt_top_props.sv */
// assertion checker for the i/o port block
`timescale 1ns/100ps
`default_nettype none
module bioprt_props #(
  parameter logic [7:0] PA_WAKE_EN = 8'h00
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire bioprt_pkg::bioprt_addr_t bus_addr,
  input wire bioprt_pkg::bioprt_byte_t bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_rmw,
  input wire logic bus_to_acc,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic [12:0] pad_in,
  input wire logic [12:0] pad_out,
  input wire logic [12:0] pad_oe,
  input wire logic wake_req,
  input wire logic ext_irq_line,
  input wire logic timer_input_line
);
  import bioprt_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_read_answer: assert property (bus_rd |=> bus_rvalid) else $error("no rvalid");
  chk_no_stray: assert property (!bus_rd && !(bus_rmw && bus_to_acc) |=> !bus_rvalid) else $error("stray rvalid");
  chk_dir_oe: assert property (bus_wr && bus_addr == 8'h13 |-> ##2 pad_oe[7:0] == ~$past(bus_wdata, 2))
    else $error("oe mismatch");
  chk_latch_holds: assert property ($changed(pad_out[7:0]) && $past(resetn, 2) |-> $past(bus_wr || bus_rmw, 2))
    else $error("pad_out moved");
  chk_reset_idle: assert property (disable iff (1'b0) !resetn |-> pad_oe == 13'h0000 && !bus_rvalid)
    else $error("reset state");
  chk_b_upper: assert property (bus_rd && bus_addr inside {8'h14, 8'h15} |=> bus_rdata[7:3] == 5'h00)
    else $error("b upper");
  chk_c_upper: assert property (bus_rd && bus_addr inside {8'h16, 8'h17} |=> bus_rdata[7:2] == 6'h00)
    else $error("c upper");
  chk_pin_share: assert property ($stable(pad_in[12:11]) [*4]
    |-> {timer_input_line, ext_irq_line} == pad_in[12:11]) else $error("c pins");
  chk_wake_change: assert property (|((pad_in[7:0] ^ $past(pad_in[7:0])) & PA_WAKE_EN & ~pad_oe[7:0])
    && $stable(pad_oe[7:0]) |-> ##[2:4] wake_req) else $error("no wake");
  chk_buzz_pair: assert property (pad_oe[9:8] == 2'b11 |-> !(pad_out[9] && pad_out[8])) else $error("pair");
  cover property (bus_rmw && bus_to_acc);
  cover property (wake_req);
  cover property (pad_oe[9:8] == 2'b11 && pad_out[8]);
endmodule
bind bioprt_top bioprt_props #(.PA_WAKE_EN(PA_WAKE_EN)) u_props (.sys_clk, .resetn, .bus_addr, .bus_wdata, .bus_wr,
  .bus_rd, .bus_rmw, .bus_to_acc, .bus_rdata, .bus_rvalid, .pad_in, .pad_out, .pad_oe, .wake_req, .ext_irq_line,
  .timer_input_line);
`default_nettype wire

/* File: verif/test_bidir_io_ports_with_buzzer.sv */
// self-checking bench for the i/o port block
`timescale 1ns/100ps
`default_nettype none
module test_bidir_io_ports_with_buzzer;
  import bioprt_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, bus_rmw = 1'b0, bus_to_acc = 1'b0;
  logic timer_overflow = 1'b0, bus_rvalid, wake_req, ext_irq_line, timer_input_line;
  bioprt_addr_t bus_addr = 8'h00;
  bioprt_byte_t bus_wdata = 8'h00;
  bioprt_op_e bus_op = BIOPRT_OP_WRITE;
  logic [2:0] bus_bit = 3'h0;
  logic [7:0] bus_rdata, d, m, e, v, b, exp_q[$];
  logic [12:0] pad_in, pad_out, pad_oe, pad_pullup, ext_val = 13'h1a5a;
  int err_total = 0, tests_run = 0, cyc = 0, seed = 32'hbb7d;
  bioprt_top #(.PA_PULLUP(8'h0f), .PA_WAKE_EN(8'hff), .BUZZ_EN(1'b1)) DUT (.sys_clk, .resetn, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rmw, .bus_op, .bus_bit, .bus_to_acc, .bus_rdata, .bus_rvalid, .timer_overflow, .pad_in,
    .pad_out, .pad_oe, .pad_pullup, .wake_req, .ext_irq_line, .timer_input_line);
  bioprt_pads u_pads (.pad_out, .pad_oe, .ext_val, .pad_in);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic go(input logic [2:0] k, input logic [7:0] a, input logic [7:0] dat);
    @(posedge sys_clk);
    {bus_wr, bus_rd, bus_rmw} <= k;
    bus_addr <= a;
    bus_wdata <= dat;
    @(posedge sys_clk);
    {bus_wr, bus_rd, bus_rmw} <= 3'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    go(3'h2, a, 8'h00);
  endtask
  // read results against the oldest note, plus the hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (bus_rvalid === 1'b1) chk({5'h00, bus_rdata}, {5'h00, exp_q.pop_front()});
    if (cyc == 3000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    resetn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(8'h13, 8'hff);
    rd(8'h15, 8'h07);
    rd(8'h17, 8'h03);
    rd(8'h18, 8'h00);
    rd(8'h12, ext_val[7:0]);
    chk(pad_pullup, 13'h000f);
    chk(pad_oe, 13'h0000);
    $display("reset test done");
    for (int k = 1; k < 4; k++) begin
      d = 8'($random(seed));
      m = 8'($random(seed));
      e = 8'($random(seed));
      ext_val[7:0] <= e;
      go(3'h4, 8'h12, d);
      go(3'h4, 8'h13, m);
      repeat (3) @(posedge sys_clk);
      v = (d & ~m) | (e & m);
      rd(8'h12, v);
      b = 8'h01 << d[2:0];
      bus_op <= bioprt_op_e'(k);
      bus_bit <= d[2:0];
      go(3'h1, 8'h12, 8'h00);
      v = (k == 1) ? v | b : (k == 2) ? v & ~b : ~v;
      v = (v & ~m) | (e & m);
      repeat (3) @(posedge sys_clk);
      rd(8'h12, v);
    end
    bus_to_acc <= 1'b1;
    bus_op <= BIOPRT_OP_CPL;
    exp_q.push_back(~v);
    go(3'h1, 8'h12, 8'h00);
    bus_to_acc <= 1'b0;
    rd(8'h12, v);
    $display("port a test done");
    go(3'h4, 8'h14, 8'hff);
    go(3'h4, 8'h15, 8'hf8);
    rd(8'h15, 8'h00);
    rd(8'h14, 8'h07);
    repeat (2) @(posedge sys_clk);
    chk({12'h000, pad_out[9]}, {12'h000, ~pad_out[8]});
    d[0] = pad_out[8];
    timer_overflow <= 1'b1;
    @(posedge sys_clk);
    timer_overflow <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({12'h000, pad_out[8]}, {12'h000, ~d[0]});
    go(3'h4, 8'h14, 8'h02);
    repeat (3) @(posedge sys_clk);
    chk({11'h000, pad_out[9:8]}, 13'h0000);
    chk({10'h000, pad_oe[10:8]}, 13'h0007);
    $display("buzzer test done");
    go(3'h4, 8'h13, 8'hff);
    repeat (5) @(posedge sys_clk);
    ext_val <= {2'b10, ext_val[10:5], ~ext_val[4], ext_val[3:0]};
    b = 8'h00;
    repeat (6) begin
      @(posedge sys_clk);
      b = b | {7'h00, wake_req};
    end
    chk({5'h00, b}, 13'h0001);
    chk({11'h000, timer_input_line, ext_irq_line}, 13'h0002);
    go(3'h4, 8'h17, 8'h00);
    $display("wake test done");
    repeat (4) @(posedge sys_clk);
    stop_test();
  end
endmodule
`default_nettype wire
